// file: tx_signal_loss_detect.sv
// transmit signal-absence detection, quality alarm and phase setting
// assumes a simple synchronous register port and one bit per bit_en
//
// Summary of operation
// - quality alarm feeds absence only when enabled
// - mode 00 turns run-length detection off
// - mode 01 counts only runs of zeros
// - modes 10 and 11 count zeros or ones
// - quality flag high while eye below threshold
// - lock loss forces quality flag to zero
// - keep bit value of last run-length event
// - run-length absence readable as status bit
// - assert at (level times 5 plus 2)*1024 bits
// - release after level*16+1 good blocks
// - phase offset is signed seven-bit value
// - control resets to mode 11, quality enabled
// - six-bit eye opening measure readable
// - quality assert level six bits, default 1
// - quality release level six bits, default 8
// - lock lost flag follows pll lock loss
module tx_signal_loss_detect import tx_absence_pkg::*; #(
  parameter int BLOCK_BITS = BLOCK_BITS_DEF
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sw_reset,
  // serial data and analog monitors
  input wire logic bit_en,
  input wire logic bit_in,
  input wire logic [5:0] eye_in,
  input wire logic pll_lock_lost,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // results
  output logic signal_absent_flag,
  output logic signed [6:0] sample_phase_offset
);
  if (BLOCK_BITS < 2)
    $error("tx_signal_loss_detect: BLOCK_BITS too small");

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  absence_ctrl_s ctrl, next_ctrl;
  logic [7:0] rl_assert, next_rl_assert;
  logic [7:0] rl_release, next_rl_release;
  logic [6:0] next_phase;
  logic [5:0] q_assert, next_q_assert;
  logic [5:0] q_release, next_q_release;
  logic [5:0] eye_opening_measure, next_eye;
  logic lock_lost_flag, next_lock_lost;
  logic next_absent;
  logic [7:0] next_rdata;
  rl_status_s rl_stat;
  logic quality_absence_flag;
  logic run_length_absence_flag;
  logic run_length_last_digit;
  logic quality_alarm_to_absence_enable;
  rl_mode_e run_length_detect_mode;

  assign run_length_absence_flag = rl_stat.absent;
  assign run_length_last_digit = rl_stat.last_digit;
  assign quality_alarm_to_absence_enable = ctrl.q_en;
  assign run_length_detect_mode = ctrl.mode;

  // ----------------------------------------------------------------
  // detectors
  // ----------------------------------------------------------------
  run_length_detector #(
    .BLOCK_BITS(BLOCK_BITS)
  ) u_run (
    .clk(clk),
    .rst_b(rst_b),
    .sw_reset(sw_reset),
    .bit_en(bit_en),
    .bit_in(bit_in),
    .mode(run_length_detect_mode),
    .assert_level(rl_assert),
    .release_level(rl_release),
    .status(rl_stat)
  );

  quality_hysteresis u_quality (
    .clk(clk),
    .rst_b(rst_b),
    .sw_reset(sw_reset),
    .eye(eye_opening_measure),
    .assert_level(q_assert),
    .release_level(q_release),
    .lock_lost(lock_lost_flag),
    .flag(quality_absence_flag)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // only defined fields are stored, so reserved write bits vanish
  always_comb begin
    next_ctrl = ctrl;
    next_rl_assert = rl_assert;
    next_rl_release = rl_release;
    next_phase = sample_phase_offset;
    next_q_assert = q_assert;
    next_q_release = q_release;
    if (sw_reset) begin
      next_ctrl = absence_ctrl_s'(RST_CTRL[CTRL_QEN_BIT:CTRL_MODE_LSB]);
      next_rl_assert = RST_RL_ASSERT;
      next_rl_release = RST_RL_RELEASE;
      next_phase = RST_PHASE;
      next_q_assert = RST_Q_ASSERT;
      next_q_release = RST_Q_RELEASE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        next_ctrl = absence_ctrl_s'(reg_wdata[CTRL_QEN_BIT:CTRL_MODE_LSB]);
      end else if (reg_addr == ADDR_RL_ASSERT) begin
        next_rl_assert = reg_wdata;
      end else if (reg_addr == ADDR_RL_RELEASE) begin
        next_rl_release = reg_wdata;
      end else if (reg_addr == ADDR_PHASE) begin
        next_phase = reg_wdata[6:0];
      end else if (reg_addr == ADDR_Q_ASSERT) begin
        next_q_assert = reg_wdata[7:QA_LSB];
      end else if (reg_addr == ADDR_Q_RELEASE) begin
        next_q_release = reg_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // monitors and combined absence
  // ----------------------------------------------------------------
  // registered once so every output leaves a flip-flop; costs a cycle
  always_comb begin
    next_eye = eye_in;
    next_lock_lost = pll_lock_lost;
    next_absent = rl_stat.absent ||
                  (ctrl.q_en && quality_absence_flag);
    if (sw_reset) begin
      next_absent = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data appears one cycle after reg_rd; unmapped reads zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = 8'h00;
      if (reg_addr == ADDR_CTRL) begin
        next_rdata[CTRL_QEN_BIT:CTRL_MODE_LSB] = ctrl;
      end else if (reg_addr == ADDR_STATUS) begin
        next_rdata[ST_QUAL_BIT] = quality_absence_flag;
        next_rdata[ST_LAST_BIT] = run_length_last_digit;
        next_rdata[ST_RL_BIT] = run_length_absence_flag;
        next_rdata[ST_ABS_BIT] = signal_absent_flag;
      end else if (reg_addr == ADDR_ALARM) begin
        next_rdata[AL_ABS_BIT] = signal_absent_flag;
        next_rdata[AL_LOL_BIT] = lock_lost_flag;
        next_rdata[AL_QUAL_BIT] = quality_absence_flag;
      end else if (reg_addr == ADDR_RL_ASSERT) begin
        next_rdata = rl_assert;
      end else if (reg_addr == ADDR_RL_RELEASE) begin
        next_rdata = rl_release;
      end else if (reg_addr == ADDR_PHASE) begin
        next_rdata[6:0] = sample_phase_offset;
      end else if (reg_addr == ADDR_EYE) begin
        next_rdata[5:0] = eye_opening_measure;
      end else if (reg_addr == ADDR_Q_ASSERT) begin
        next_rdata[7:QA_LSB] = q_assert;
      end else if (reg_addr == ADDR_Q_RELEASE) begin
        next_rdata[5:0] = q_release;
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= absence_ctrl_s'(RST_CTRL[CTRL_QEN_BIT:CTRL_MODE_LSB]);
      rl_assert <= RST_RL_ASSERT;
      rl_release <= RST_RL_RELEASE;
      sample_phase_offset <= RST_PHASE;
      q_assert <= RST_Q_ASSERT;
      q_release <= RST_Q_RELEASE;
      eye_opening_measure <= '1; // wide open: no false alarm after reset
      lock_lost_flag <= 1'b0;
      signal_absent_flag <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      rl_assert <= next_rl_assert;
      rl_release <= next_rl_release;
      sample_phase_offset <= next_phase;
      q_assert <= next_q_assert;
      q_release <= next_q_release;
      eye_opening_measure <= next_eye;
      lock_lost_flag <= next_lock_lost;
      signal_absent_flag <= next_absent;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_ABSENT_OR: assert property (@(posedge clk)
    disable iff (!rst_b)
    !sw_reset |=> signal_absent_flag ==
      ($past(rl_stat.absent) || ($past(ctrl.q_en) &&
       $past(quality_absence_flag))))
    else $error("absence flag not the combined alarm");
  AST_Q_MASKED: assert property (@(posedge clk)
    disable iff (!rst_b)
    !ctrl.q_en && !rl_stat.absent |=> !signal_absent_flag)
    else $error("masked quality alarm raised absence");
  AST_SW_RESET_CTRL: assert property (@(posedge clk)
    disable iff (!rst_b)
    sw_reset |=> ctrl.mode == RL_ANY_B && ctrl.q_en)
    else $error("control not at reset value");
  AST_STATUS_READ: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[ST_RL_BIT] == $past(rl_stat.absent) &&
      reg_rdata[7:5] == 3'h0 && !reg_rdata[1])
    else $error("status read wrong");
  AST_PHASE_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_PHASE |=>
      sample_phase_offset == $past(reg_wdata[6:0]))
    else $error("phase write lost");
  AST_LOL_FOLLOW: assert property (@(posedge clk)
    disable iff (!rst_b)
    pll_lock_lost |=> lock_lost_flag)
    else $error("lock lost not flagged");

  // ----------------------------------------------------------------
  // register field checks
  // ----------------------------------------------------------------
  // enable and mode share one byte; a swapped field order would turn
  // the detector on when software means to switch it off
  AST_CTRL_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_CTRL |=>
      ctrl.q_en == $past(reg_wdata[CTRL_QEN_BIT]) &&
      ctrl.mode == $past(reg_wdata[CTRL_QEN_BIT-1:CTRL_MODE_LSB]))
    else $error("control write misplaced");
  AST_CTRL_READ: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_CTRL |=>
      reg_rdata[7:4] == 4'h0 && !reg_rdata[0] &&
      reg_rdata[CTRL_QEN_BIT] == $past(ctrl.q_en))
    else $error("control read wrong");
  AST_RL_ASSERT_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_RL_ASSERT |=>
      rl_assert == $past(reg_wdata))
    else $error("assert level write lost");
  AST_RL_RELEASE_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_RL_RELEASE |=>
      rl_release == $past(reg_wdata))
    else $error("release level write lost");
  AST_Q_ASSERT_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_Q_ASSERT |=>
      q_assert == $past(reg_wdata[7:QA_LSB]))
    else $error("quality assert level write lost");
  AST_Q_RELEASE_WRITE: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_wr && !sw_reset && reg_addr == ADDR_Q_RELEASE |=>
      q_release == $past(reg_wdata[5:0]))
    else $error("quality release level write lost");
  // the eye measure is only delayed, never filtered
  AST_EYE_FOLLOW: assert property (@(posedge clk)
    disable iff (!rst_b)
    rst_b |=> eye_opening_measure == $past(eye_in))
    else $error("eye measure not following");
  AST_STATUS_BITS: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[ST_LAST_BIT] == $past(run_length_last_digit) &&
      reg_rdata[ST_QUAL_BIT] == $past(quality_absence_flag) &&
      reg_rdata[ST_ABS_BIT] == $past(signal_absent_flag))
    else $error("status bits wrong");
  AST_ALARM_READ: assert property (@(posedge clk)
    disable iff (!rst_b)
    reg_rd && reg_addr == ADDR_ALARM |=>
      reg_rdata[AL_LOL_BIT] == $past(lock_lost_flag) &&
      reg_rdata[7:6] == 2'h0)
    else $error("alarm read wrong");
  AST_SW_RESET_ABSENT: assert property (@(posedge clk)
    disable iff (!rst_b)
    sw_reset |=> !signal_absent_flag)
    else $error("absence survived software reset");
  COV_QUAL_ABSENT: cover property (@(posedge clk)
    ctrl.q_en && quality_absence_flag ##1 signal_absent_flag);
  COV_NEG_PHASE: cover property (@(posedge clk) sample_phase_offset[6]);
  COV_LAST_ONE: cover property (@(posedge clk)
    rl_stat.absent && rl_stat.last_digit);
endmodule // tx_signal_loss_detect

// file: tx_absence_pkg.sv
// shared constants and types of the transmit signal-absence block
// assumes a single clock and one serial bit per bit_en pulse
package tx_absence_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM = 8'h89;
  localparam logic [7:0] ADDR_CTRL = 8'h8A;
  localparam logic [7:0] ADDR_STATUS = 8'h8B;
  localparam logic [7:0] ADDR_RL_ASSERT = 8'h91;
  localparam logic [7:0] ADDR_RL_RELEASE = 8'h92;
  localparam logic [7:0] ADDR_PHASE = 8'h98;
  localparam logic [7:0] ADDR_EYE = 8'h99;
  localparam logic [7:0] ADDR_Q_ASSERT = 8'h9A;
  localparam logic [7:0] ADDR_Q_RELEASE = 8'h9B;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h0E;
  localparam logic [7:0] RST_RL_ASSERT = 8'h00;
  localparam logic [7:0] RST_RL_RELEASE = 8'h00;
  localparam logic [6:0] RST_PHASE = 7'h00;
  localparam logic [5:0] RST_Q_ASSERT = 6'h01;
  localparam logic [5:0] RST_Q_RELEASE = 6'h08;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_QEN_BIT = 3;
  localparam int CTRL_MODE_LSB = 1;
  localparam int ST_QUAL_BIT = 4;
  localparam int ST_LAST_BIT = 3;
  localparam int ST_RL_BIT = 2;
  localparam int ST_ABS_BIT = 0;
  localparam int AL_ABS_BIT = 5;
  localparam int AL_LOL_BIT = 4;
  localparam int AL_QUAL_BIT = 0;
  localparam int QA_LSB = 2;
  // ----------------------------------------------------------------
  // run-length scaling
  // ----------------------------------------------------------------
  localparam int RL_MULT = 5;
  localparam int RL_OFFSET = 2;
  localparam int RL_REL_MULT = 16;
  localparam int RL_REL_OFFSET = 1;
  localparam int BLOCK_BITS_DEF = 1024;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RL_OFF = 2'b00, RL_ZEROS = 2'b01, RL_ANY_A = 2'b10, RL_ANY_B = 2'b11
  } rl_mode_e;
  typedef enum logic {RL_WATCH = 1'b0, RL_ABSENT = 1'b1} rl_state_e;
  // field order matches the control byte: enable sits above the mode
  typedef struct packed {logic q_en; rl_mode_e mode;} absence_ctrl_s;
  typedef struct packed {logic absent; logic last_digit;} rl_status_s;
endpackage

// file: quality_hysteresis.sv
// eye-opening quality alarm with assert and release levels
// assumes eye measure and lock flag are synchronous to clk
module quality_hysteresis import tx_absence_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sw_reset,
  // measure and levels
  input wire logic [5:0] eye,
  input wire logic [5:0] assert_level,
  input wire logic [5:0] release_level,
  input wire logic lock_lost,
  // alarm
  output logic flag
);
  logic next_flag;

  // alarm sets below the assert level, clears at the release level
  always_comb begin
    next_flag = flag;
    if (sw_reset || lock_lost) begin
      next_flag = 1'b0;
    end else if (!flag && eye < assert_level) begin
      next_flag = 1'b1;
    end else if (flag && eye >= release_level) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) flag <= 1'b0;
    else flag <= next_flag;
  end

  AST_LOL_FORCES_ZERO: assert property (@(posedge clk)
    disable iff (!rst_b)
    lock_lost |=> !flag) else $error("quality flag set under lock loss");
  AST_Q_SET: assert property (@(posedge clk)
    disable iff (!rst_b)
    !sw_reset && !lock_lost && eye < assert_level |=> flag)
    else $error("quality flag missed low eye");
  AST_Q_HOLD: assert property (@(posedge clk)
    disable iff (!rst_b)
    flag && !lock_lost && !sw_reset && eye < release_level |=> flag)
    else $error("quality flag dropped inside hysteresis");
endmodule // quality_hysteresis

// file: run_length_detector.sv
// run-length signal-absence detector with block-based release
// assumes one serial bit per bit_en pulse
module run_length_detector import tx_absence_pkg::*; #(
  parameter int BLOCK_BITS = BLOCK_BITS_DEF,
  parameter int RUN_W = 21,
  parameter int BLK_W = 10,
  parameter int GOOD_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sw_reset,
  // serial data
  input wire logic bit_en,
  input wire logic bit_in,
  // settings
  input wire rl_mode_e mode,
  input wire logic [7:0] assert_level,
  input wire logic [7:0] release_level,
  // result
  output rl_status_s status
);
  if (BLOCK_BITS < 2 || BLOCK_BITS > (1 << BLK_W) ||
      ((255 * RL_MULT + RL_OFFSET) * BLOCK_BITS) >= (1 << RUN_W) ||
      (255 * RL_REL_MULT + RL_REL_OFFSET) >= (1 << GOOD_W))
    $error("run_length_detector: widths too small");

  rl_state_e state, next_state;
  logic [RUN_W-1:0] run_cnt, next_run_cnt, run_len, assert_thr;
  logic [BLK_W-1:0] blk_cnt, next_blk_cnt;
  logic [GOOD_W-1:0] good_cnt, next_good_cnt, release_thr;
  logic prev_bit, next_prev_bit, blk_trans, next_blk_trans;
  logic last_digit, next_last_digit, counted, same, end_blk, trans;

  // thresholds scale the 8-bit settings into bits and blocks
  assign assert_thr = RUN_W'((32'(assert_level) * RL_MULT + RL_OFFSET)
                             * BLOCK_BITS);
  assign release_thr = GOOD_W'(32'(release_level) * RL_REL_MULT
                               + RL_REL_OFFSET);

  // run, block and state update on each bit
  always_comb begin
    next_state = state;
    next_run_cnt = run_cnt;
    next_blk_cnt = blk_cnt;
    next_good_cnt = good_cnt;
    next_prev_bit = prev_bit;
    next_blk_trans = blk_trans;
    next_last_digit = last_digit;
    same = (bit_in == prev_bit);
    counted = (mode == RL_ZEROS) ? !bit_in : 1'b1;
    run_len = '0;
    if (counted) begin
      // saturate rather than wrap, so a very long run never looks short
      run_len = !same ? RUN_W'(1) :
                (run_cnt == '1) ? run_cnt : run_cnt + 1'b1;
    end
    end_blk = (blk_cnt == BLK_W'(BLOCK_BITS - 1));
    trans = blk_trans || !same;
    if (sw_reset || mode == RL_OFF) begin
      next_state = RL_WATCH;
      next_run_cnt = '0;
      next_blk_cnt = '0;
      next_good_cnt = '0;
      next_blk_trans = 1'b0;
      next_last_digit = 1'b0;
    end else if (bit_en) begin
      next_prev_bit = bit_in;
      next_run_cnt = run_len;
      next_blk_cnt = end_blk ? '0 : blk_cnt + 1'b1;
      next_blk_trans = end_blk ? 1'b0 : trans;
      case (state)
        RL_WATCH: begin
          if (counted && run_len >= assert_thr) begin
            next_state = RL_ABSENT;
            next_last_digit = bit_in;
            next_good_cnt = '0;
          end
        end
        RL_ABSENT: begin
          if (end_blk && !trans) begin
            next_good_cnt = '0;
          end else if (end_blk && good_cnt + 1'b1 >= release_thr) begin
            next_state = RL_WATCH;
            next_good_cnt = '0;
          end else if (end_blk) begin
            next_good_cnt = good_cnt + 1'b1;
          end
        end
        default: next_state = RL_WATCH;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RL_WATCH;
      run_cnt <= '0;
      blk_cnt <= '0;
      good_cnt <= '0;
      prev_bit <= 1'b0;
      blk_trans <= 1'b0;
      last_digit <= 1'b0;
    end else begin
      state <= next_state;
      run_cnt <= next_run_cnt;
      blk_cnt <= next_blk_cnt;
      good_cnt <= next_good_cnt;
      prev_bit <= next_prev_bit;
      blk_trans <= next_blk_trans;
      last_digit <= next_last_digit;
    end
  end

  assign status.absent = (state == RL_ABSENT);
  assign status.last_digit = last_digit;

  AST_RL_OFF: assert property (@(posedge clk)
    disable iff (!rst_b)
    mode == RL_OFF |=> !status.absent) else $error("absence while off");
  AST_RL_ZERO_ONLY: assert property (@(posedge clk)
    disable iff (!rst_b)
    mode == RL_ZEROS && $rose(status.absent) |-> !status.last_digit)
    else $error("zeros mode flagged on ones");
  AST_RL_THRESH: assert property (@(posedge clk)
    disable iff (!rst_b)
    $rose(status.absent) |-> run_cnt >= assert_thr)
    else $error("absence before threshold");
  COV_RL_ASSERT: cover property (@(posedge clk) $rose(status.absent));
  COV_RL_RELEASE: cover property (@(posedge clk) $fell(status.absent));
endmodule // run_length_detector

// file: sig_source.sv
// ------------------------------------------------------------------
// serial bit source standing in for the host transmit data path
// ------------------------------------------------------------------
// assumes the bench changes pat by non-blocking assignment on negedge
module sig_source (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pattern select: 0 idle, 1 zeros, 2 ones, 3 toggling
  input wire logic [1:0] pat,
  // serial data towards the detector
  output logic bit_en,
  output logic bit_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // falling edge launch keeps bits settled at the sampling edge
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_en <= 1'b0;
      bit_in <= 1'b0;
    end else begin
      bit_en <= (pat != 2'h0);
      case (pat)
        2'h1: bit_in <= 1'b0;
        2'h2: bit_in <= 1'b1;
        // idle line wanders so a stale value is never mistaken for data
        default: bit_in <= ~bit_in;
      endcase
    end
  end
endmodule // sig_source

// file: tb.sv
// ------------------------------------------------------------------
// self-checking bench for the transmit signal-absence block
// ------------------------------------------------------------------
// assumes a short block length so run-length counts stay brief
module tb;
  import tx_absence_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BB = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sw_reset = 1'b0;
  logic [1:0] pat = 2'h0;
  logic bit_en;
  logic bit_in;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] eye_in = 6'h20;
  logic pll_lock_lost = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic signal_absent_flag;
  logic signed [6:0] sample_phase_offset;
  int error_cnt = 0;
  int checks = 0;
  int thr;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------------
  // design and data source
  // ------------------------------------------------------------------
  tx_signal_loss_detect #(.BLOCK_BITS(BB)) dut (
    .clk(clk), .rst_b(rst_b), .sw_reset(sw_reset),
    .bit_en(bit_en), .bit_in(bit_in), .eye_in(eye_in),
    .pll_lock_lost(pll_lock_lost), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .signal_absent_flag(signal_absent_flag),
    .sample_phase_offset(sample_phase_offset)
  );
  sig_source src (
    .clk(clk), .rst_b(rst_b), .pat(pat), .bit_en(bit_en), .bit_in(bit_in)
  );
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, launched on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(negedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(negedge clk);
    reg_rd <= 1'b0;
    chk(reg_rdata, exp);
  endtask
  // wait for the flag to reach v between lo and hi cycles
  task automatic go(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (signal_absent_flag !== v && n <= hi) begin
      @(negedge clk);
      n++;
    end
    if (n > hi) begin
      chk({7'h00, signal_absent_flag}, {7'h00, v});
      print_verdict();
    end
    chk({7'h00, n < lo}, 8'h00);
  endtask
  // the flag must keep value v for cyc cycles
  task automatic hold(input logic v, input int cyc);
    for (int i = 0; i < cyc; i++) begin
      @(negedge clk);
      if (signal_absent_flag !== v) begin
        chk({7'h00, signal_absent_flag}, {7'h00, v});
        break;
      end
    end
    checks++;
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst_b <= 1'b1;
    // reset values of the settings
    rchk(ADDR_CTRL, RST_CTRL);
    rchk(ADDR_RL_ASSERT, 8'h00);
    rchk(ADDR_PHASE, 8'h00);
    rchk(ADDR_Q_ASSERT, {RST_Q_ASSERT, 2'b00});
    rchk(ADDR_Q_RELEASE, {2'b00, RST_Q_RELEASE});
    rchk(ADDR_EYE, 8'h20);
    // reserved bits, read-only and unmapped places
    wr(ADDR_CTRL, 8'hFF);
    rchk(ADDR_CTRL, 8'h0E);
    wr(ADDR_PHASE, 8'hC1);
    rchk(ADDR_PHASE, 8'h41);
    chk({1'b0, sample_phase_offset}, 8'h41);
    chk({7'h00, sample_phase_offset < 0}, 8'h01);
    wr(ADDR_STATUS, 8'hFF);
    rchk(ADDR_STATUS, 8'h00);
    rchk(8'h00, 8'h00);
    // detector off ignores a long run
    wr(ADDR_CTRL, 8'h08);
    pat <= 2'h1;
    hold(1'b0, 40);
    // zeros-only mode ignores ones, then trips on zeros
    wr(ADDR_CTRL, 8'h0A);
    pat <= 2'h2;
    hold(1'b0, 40);
    thr = (0 * RL_MULT + RL_OFFSET) * BB;
    pat <= 2'h1;
    go(1'b1, thr - 3, thr + 4);
    rchk(ADDR_STATUS, 8'h05);
    pat <= 2'h3;
    go(1'b0, 1, 2 * BB + 4);
    // larger assert level
    wr(ADDR_RL_ASSERT, 8'h01);
    thr = (1 * RL_MULT + RL_OFFSET) * BB;
    pat <= 2'h1;
    go(1'b1, thr - 3, thr + 4);
    // a block without transition restarts the release count
    wr(ADDR_RL_RELEASE, 8'h01);
    pat <= 2'h3;
    hold(1'b1, 12 * BB);
    pat <= 2'h1;
    hold(1'b1, 3 * BB);
    pat <= 2'h3;
    thr = (1 * RL_REL_MULT + RL_REL_OFFSET) * BB;
    go(1'b0, thr - BB - 1, thr + BB + 4);
    wr(ADDR_RL_RELEASE, 8'h00);
    wr(ADDR_RL_ASSERT, 8'h00);
    // both identical-digit modes trip on ones
    for (int m = 2; m < 4; m++) begin
      wr(ADDR_CTRL, {4'h0, 1'b1, m[1:0], 1'b0});
      pat <= 2'h2;
      go(1'b1, 2 * BB - 3, 2 * BB + 4);
      rchk(ADDR_STATUS, 8'h0D);
      pat <= 2'h3;
      go(1'b0, 1, 2 * BB + 4);
    end
    // quality alarm with hysteresis, lock loss and enable
    pat <= 2'h0;
    eye_in <= 6'h00;
    go(1'b1, 2, 6);
    rchk(ADDR_STATUS, 8'h19);
    eye_in <= RST_Q_RELEASE - 6'h01;
    hold(1'b1, 10);
    eye_in <= RST_Q_RELEASE;
    go(1'b0, 2, 6);
    eye_in <= 6'h00;
    pll_lock_lost <= 1'b1;
    hold(1'b0, 10);
    rchk(ADDR_ALARM, 8'h10);
    pll_lock_lost <= 1'b0;
    go(1'b1, 2, 6);
    wr(ADDR_CTRL, 8'h06);
    go(1'b0, 0, 4);
    rchk(ADDR_STATUS, 8'h18);
    // software reset restores the settings
    wr(ADDR_RL_ASSERT, 8'h05);
    sw_reset <= 1'b1;
    @(negedge clk);
    sw_reset <= 1'b0;
    rchk(ADDR_RL_ASSERT, 8'h00);
    rchk(ADDR_CTRL, RST_CTRL);
    print_verdict();
  end
endmodule // tb
